// *** lpc_pkg.sv ***
// Constants, types and carriers for the low-power clock select block
// Operation
// RULE_01: Stop request enters pseudo-watch or stop mode
// RULE_02: Stop request reads zero, clears on wake
// RULE_03: Sleep request enters sleep, reads zero
// RULE_04: Stop request beats sleep in same write
// RULE_05: Float select tristates pins in watch/stop
// RULE_06: Software reset pulse three cycles after write
// RULE_07: Watch entry on zero, reads one
// RULE_08: Pause field maps to 0/9/17/33 cycles
// RULE_09: Pause field cleared by full resets only
// RULE_10: Self-refresh asserted in sleep, watch, stop; code asserts it in sleep only while the main clock status is set
// RULE_11: Sub/main status shows active clock, wait
// RULE_12: PLL/main status, fixed 4096-cycle PLL wait
// RULE_13: Wait select sets stop release wait
// RULE_14: Wait select set only by power-on
// RULE_15: Main select rising starts wait, clears timebase
// RULE_16: Subclock wins when both selects zero
// RULE_17: Main/sub select set by every reset
// RULE_18: PLL select falling starts wait, clears timebase
// RULE_19: PLL/main select set by full resets
// RULE_20: Multiplier cleared by full resets only
// RULE_21: Multiplier writes ignored while PLL selected
// RULE_22: Multiplier gives times one to four
// RULE_23: Pending interrupt blocks low-power entry
// RULE_24: Clock switches and status update after wait
// RULE_25: Each field sees its own reset qualifiers
package lpc_pkg;
	// Register offsets
	localparam logic [7:0] LPM_ADDR = 8'ha0;
	localparam logic [7:0] CKS_ADDR = 8'ha1;
	// Mode control fields
	localparam int STOP_BIT = 7;
	localparam int SLEEP_BIT = 6;
	localparam int FLOAT_BIT = 5;
	localparam int SWRST_BIT = 4;
	localparam int WATCH_BIT = 3;
	localparam int PAUSE_LSB = 1;
	localparam int REFRESH_BIT = 0;
	// Clock select fields
	localparam int MSEL_BIT = 3;
	localparam int PSEL_BIT = 2;
	localparam int WS_LSB = 4;
	localparam int MUL_LSB = 0;
	// Reset values
	localparam logic [1:0] WS_RST = 2'h3;
	localparam logic [1:0] PAUSE_RST = 2'h0;
	localparam logic [1:0] MUL_RST = 2'h0;
	// Pause lengths in clock cycles
	localparam logic [5:0] PAUSE_0 = 6'h00;
	localparam logic [5:0] PAUSE_1 = 6'h09;
	localparam logic [5:0] PAUSE_2 = 6'h11;
	localparam logic [5:0] PAUSE_3 = 6'h21;
	// Timing counts
	localparam logic [18:0] PLL_WAIT_CYC = 19'h01000;
	localparam logic [1:0] SWRST_DELAY = 2'h3;
	localparam logic [18:0] CNT_ONE = 19'h00001;

	typedef enum logic [2:0] {
		MODE_RUN, MODE_SLEEP, MODE_PSEUDO,
		MODE_WATCH, MODE_STOP, MODE_WAKE
	} mode_e;

	typedef enum logic [1:0] {SRC_SUB, SRC_MAIN, SRC_PLL} clk_src_e;

	// Reset qualifiers from the reset controller
	typedef struct packed {
		logic por;
		logic hstby;
		logic wdt;
		logic ext;
	} rst_src_s;

	// Standby controls to the clock generator and pads
	typedef struct packed {
		logic cpu_halt;
		logic periph_stop;
		logic main_osc_stop;
		logic sub_osc_stop;
		logic pins_hiz;
		logic self_refresh;
	} stby_s;
endpackage

// *** low_power_clock_select.sv ***
// Standby mode and machine clock selection control
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
module low_power_clock_select #(
	parameter int unsigned WAIT_1 = 16384,
	parameter int unsigned WAIT_2 = 65536,
	parameter int unsigned WAIT_3 = 262144,
	parameter int unsigned SUB_WAIT = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire lpc_pkg::rst_src_s rst_src,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Interrupt status
	input wire logic irq_pending,
	input wire logic wake_irq,
	// Standby and clock controls
	output lpc_pkg::mode_e mode,
	output lpc_pkg::stby_s stby,
	output lpc_pkg::clk_src_e clk_src,
	output logic [2:0] pll_factor,
	output logic [5:0] pause_cycles,
	output logic osc_wait,
	output logic tbt_clear,
	output logic sw_reset
);

	function automatic logic [18:0] ws_cycles(input logic [1:0] ws);
		logic [18:0] c;
		c = 19'h0;
		unique case (ws)
			2'h0: c = 19'h0;
			2'h1: c = WAIT_1[18:0];
			2'h2: c = WAIT_2[18:0];
			2'h3: c = WAIT_3[18:0];
		endcase
		return c;
	endfunction

	function automatic logic [5:0] pause_map(input logic [1:0] p);
		logic [5:0] c;
		c = lpc_pkg::PAUSE_0;
		unique case (p)
			2'h0: c = lpc_pkg::PAUSE_0;
			2'h1: c = lpc_pkg::PAUSE_1;
			2'h2: c = lpc_pkg::PAUSE_2;
			2'h3: c = lpc_pkg::PAUSE_3;
		endcase
		return c;
	endfunction

	logic float_reg;
	logic refresh_en_reg;
	logic [1:0] pause_reg;
	logic [1:0] ws_reg;
	logic msel_reg;
	logic psel_reg;
	logic [1:0] mul_reg;
	logic sub_st_reg;
	logic pll_st_reg;
	logic [18:0] mcnt_reg;
	logic [18:0] pcnt_reg;
	logic [18:0] wcnt_reg;
	logic [18:0] wcnt_next;
	lpc_pkg::mode_e mode_reg;
	lpc_pkg::mode_e mode_next;
	logic [1:0] swc_reg;
	logic sw_rst_reg;
	logic tbt_clr_reg;
	logic [7:0] rdata_reg;

	// Reset qualifier groups [RULE_25]
	wire rst_por = rst | rst_src.por;
	wire rst_full = rst_por | rst_src.hstby | rst_src.wdt;
	wire rst_any = rst_full | rst_src.ext | sw_rst_reg;

	// Register decode
	wire wr_lpm = reg_wr && reg_addr == lpc_pkg::LPM_ADDR;
	wire wr_cks = reg_wr && reg_addr == lpc_pkg::CKS_ADDR;
	wire rd_lpm = reg_rd && reg_addr == lpc_pkg::LPM_ADDR;
	wire rd_cks = reg_rd && reg_addr == lpc_pkg::CKS_ADDR;
	wire stop_wr = wr_lpm && reg_wdata[lpc_pkg::STOP_BIT];
	wire watch_wr = wr_lpm && !reg_wdata[lpc_pkg::WATCH_BIT];
	wire sleep_wr = wr_lpm && reg_wdata[lpc_pkg::SLEEP_BIT];
	wire swrst_wr = wr_lpm && !reg_wdata[lpc_pkg::SWRST_BIT];
	wire msel_wd = reg_wdata[lpc_pkg::MSEL_BIT];
	wire psel_wd = reg_wdata[lpc_pkg::PSEL_BIT];
	wire to_main = wr_cks && msel_wd && !msel_reg;
	wire to_sub = wr_cks && !msel_wd && msel_reg;
	wire to_pll = wr_cks && !psel_wd && psel_reg;
	wire to_mainp = wr_cks && psel_wd && !psel_reg;
	wire pseudo_ok = msel_reg && !psel_reg;
	// Entry only from run, never over a pending interrupt
	wire may_enter = mode_reg == lpc_pkg::MODE_RUN && !irq_pending;

	// Read data: write-only bits read as constants
	wire [7:0] lpm_rd = {1'b0, 1'b0, float_reg, 1'b1, 1'b1,
		pause_reg, refresh_en_reg}; // [RULE_02] [RULE_03] [RULE_06] [RULE_07]
	wire [7:0] cks_rd = {sub_st_reg, pll_st_reg, ws_reg,
		msel_reg, psel_reg, mul_reg};
	wire [7:0] rd_mux = rd_lpm ? lpm_rd : (rd_cks ? cks_rd : 8'h00);

	// Standby mode sequencing
	always_comb begin
		mode_next = mode_reg;
		wcnt_next = wcnt_reg;
		unique case (mode_reg)
			lpc_pkg::MODE_RUN: begin
				if (may_enter && stop_wr) begin
					// Stop beats sleep and watch [RULE_04]
					mode_next = pseudo_ok ? lpc_pkg::MODE_PSEUDO :
						lpc_pkg::MODE_STOP; // [RULE_01]
				end else if (may_enter && watch_wr) begin
					mode_next = lpc_pkg::MODE_WATCH; // [RULE_07]
				end else if (may_enter && sleep_wr) begin
					mode_next = lpc_pkg::MODE_SLEEP; // [RULE_03] [RULE_23]
				end
			end
			lpc_pkg::MODE_SLEEP, lpc_pkg::MODE_WATCH: begin
				// Wake returns the write-only bits to idle [RULE_02]
				if (wake_irq)
					mode_next = lpc_pkg::MODE_RUN;
			end
			lpc_pkg::MODE_PSEUDO: begin
				// PLL must settle again before the core runs
				if (wake_irq) begin
					mode_next = lpc_pkg::MODE_WAKE;
					wcnt_next = lpc_pkg::PLL_WAIT_CYC;
				end
			end
			lpc_pkg::MODE_STOP: begin
				if (wake_irq) begin
					mode_next = lpc_pkg::MODE_WAKE;
					// Main oscillator restart only when main runs [RULE_13]
					wcnt_next = sub_st_reg ? ws_cycles(ws_reg) : 19'h0;
				end
			end
			lpc_pkg::MODE_WAKE: begin
				if (wcnt_reg == 19'h0)
					mode_next = lpc_pkg::MODE_RUN;
				else
					wcnt_next = wcnt_reg - lpc_pkg::CNT_ONE;
			end
			default: mode_next = lpc_pkg::MODE_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst_any) begin
			mode_reg <= lpc_pkg::MODE_RUN;
			wcnt_reg <= 19'h0;
		end else begin
			mode_reg <= mode_next;
			wcnt_reg <= wcnt_next;
		end
	end

	// Fields cleared by any reset [RULE_25]
	always_ff @(posedge clk) begin
		if (rst_any) begin
			float_reg <= 1'b0;
			refresh_en_reg <= 1'b0;
		end else if (wr_lpm) begin
			float_reg <= reg_wdata[lpc_pkg::FLOAT_BIT]; // [RULE_05]
			refresh_en_reg <= reg_wdata[lpc_pkg::REFRESH_BIT]; // [RULE_10]
		end
	end

	// Pause field survives pin and software resets
	always_ff @(posedge clk) begin
		if (rst_full)
			pause_reg <= lpc_pkg::PAUSE_RST; // [RULE_09]
		else if (wr_lpm)
			pause_reg <= reg_wdata[lpc_pkg::PAUSE_LSB +: 2];
	end

	// Wait select survives all but power-on
	always_ff @(posedge clk) begin
		if (rst_por)
			ws_reg <= lpc_pkg::WS_RST; // [RULE_14]
		else if (wr_cks)
			ws_reg <= reg_wdata[lpc_pkg::WS_LSB +: 2];
	end

	// Multiplier locked while the PLL drives the core
	always_ff @(posedge clk) begin
		if (rst_full)
			mul_reg <= lpc_pkg::MUL_RST; // [RULE_20]
		else if (wr_cks && psel_reg)
			mul_reg <= reg_wdata[lpc_pkg::MUL_LSB +: 2]; // [RULE_21]
	end

	// Main/sub path: select, wait counter, status
	always_ff @(posedge clk) begin
		if (rst_any) begin
			msel_reg <= 1'b1; // [RULE_17]
			sub_st_reg <= 1'b1;
			mcnt_reg <= 19'h0;
		end else begin
			if (wr_cks)
				msel_reg <= msel_wd;
			if (to_main)
				mcnt_reg <= ws_cycles(ws_reg); // [RULE_15]
			else if (to_sub)
				mcnt_reg <= SUB_WAIT[18:0];
			else if (mcnt_reg != 19'h0)
				mcnt_reg <= mcnt_reg - lpc_pkg::CNT_ONE;
			// Status follows only once the wait is over [RULE_11] [RULE_24]
			if (mcnt_reg == 19'h0 && !to_main && !to_sub)
				sub_st_reg <= msel_reg;
		end
	end

	// PLL/main path: select, fixed wait, status
	always_ff @(posedge clk) begin
		if (rst_full) begin
			psel_reg <= 1'b1; // [RULE_19]
			pll_st_reg <= 1'b1;
			pcnt_reg <= 19'h0;
		end else begin
			if (wr_cks)
				psel_reg <= psel_wd;
			if (to_pll)
				pcnt_reg <= lpc_pkg::PLL_WAIT_CYC; // [RULE_12] [RULE_18]
			else if (to_mainp)
				pcnt_reg <= 19'h0;
			else if (pcnt_reg != 19'h0)
				pcnt_reg <= pcnt_reg - lpc_pkg::CNT_ONE;
			if (pcnt_reg == 19'h0 && !to_pll && !to_mainp)
				pll_st_reg <= psel_reg; // [RULE_24]
		end
	end

	// Timebase clear on oscillator restarts and stop entry
	wire stop_entry = mode_reg == lpc_pkg::MODE_RUN &&
		(mode_next == lpc_pkg::MODE_STOP ||
		mode_next == lpc_pkg::MODE_PSEUDO);

	always_ff @(posedge clk) begin
		if (rst_any)
			tbt_clr_reg <= 1'b0;
		else
			tbt_clr_reg <= to_main || to_pll || stop_entry; // [RULE_15] [RULE_18]
	end

	// Software reset after a fixed delay
	always_ff @(posedge clk) begin
		if (rst_full) begin
			swc_reg <= 2'h0;
			sw_rst_reg <= 1'b0;
		end else begin
			sw_rst_reg <= swc_reg == 2'h1; // [RULE_06]
			if (swrst_wr && swc_reg == 2'h0)
				swc_reg <= lpc_pkg::SWRST_DELAY - 2'h1;
			else if (swc_reg != 2'h0)
				swc_reg <= swc_reg - 2'h1;
		end
	end

	// Read data valid in the cycle after the strobe only
	always_ff @(posedge clk) begin
		if (rst)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rd_mux;
	end

	// Output decode
	wire lp_deep = mode_reg == lpc_pkg::MODE_WATCH ||
		mode_reg == lpc_pkg::MODE_STOP ||
		mode_reg == lpc_pkg::MODE_PSEUDO;
	wire sleep_fast = mode_reg == lpc_pkg::MODE_SLEEP && sub_st_reg;

	assign mode = mode_reg;
	assign reg_rdata = rdata_reg;
	assign tbt_clear = tbt_clr_reg;
	assign sw_reset = sw_rst_reg;
	assign osc_wait = msel_reg != sub_st_reg || psel_reg != pll_st_reg;
	// Subclock wins whatever the PLL select says [RULE_16]
	assign clk_src = !sub_st_reg ? lpc_pkg::SRC_SUB :
		(pll_st_reg ? lpc_pkg::SRC_MAIN : lpc_pkg::SRC_PLL);
	assign pll_factor = {1'b0, mul_reg} + 3'h1; // [RULE_22]
	assign pause_cycles = pause_map(pause_reg); // [RULE_08]
	assign stby.cpu_halt = mode_reg != lpc_pkg::MODE_RUN;
	assign stby.periph_stop = lp_deep;
	assign stby.main_osc_stop = mode_reg == lpc_pkg::MODE_WATCH ||
		mode_reg == lpc_pkg::MODE_STOP || !sub_st_reg;
	assign stby.sub_osc_stop = mode_reg == lpc_pkg::MODE_STOP;
	assign stby.pins_hiz = float_reg && lp_deep; // [RULE_05]
	assign stby.self_refresh = refresh_en_reg &&
		(lp_deep || sleep_fast); // [RULE_10]

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst_any);

	sequence swrst_req;
		swrst_wr && swc_reg == 2'h0 && !rst_any;
	endsequence

	// Low for two cycles, then the pulse in the third
	sequence swrst_pulse;
		!sw_reset ##1 !sw_reset ##1 sw_reset;
	endsequence

	// The pulse itself resets the block, so only full resets disable
	sw_reset_delay_a: assert property ( // [RULE_06]
		disable iff (rst_full)
		swrst_req |=> swrst_pulse)
		else $error("software reset not three cycles after write");

	pll_mul_lock_a: assert property ( // [RULE_21]
		wr_cks && !psel_reg |=> $stable(mul_reg))
		else $error("multiplier changed while PLL selected");

	sleep_block_a: assert property ( // [RULE_23]
		mode == lpc_pkg::MODE_RUN && irq_pending |=>
			mode == lpc_pkg::MODE_RUN)
		else $error("low-power entry over pending interrupt");

	stop_select_a: assert property ( // [RULE_01]
		may_enter && stop_wr |=> mode ==
			($past(pseudo_ok) ? lpc_pkg::MODE_PSEUDO : lpc_pkg::MODE_STOP))
		else $error("stop request took wrong mode");

	stop_over_sleep_a: assert property ( // [RULE_04]
		may_enter && stop_wr && sleep_wr |=>
			mode != lpc_pkg::MODE_SLEEP)
		else $error("sleep taken over stop request");

	pins_float_a: assert property ( // [RULE_05]
		stby.pins_hiz |-> float_reg && mode != lpc_pkg::MODE_RUN
			&& mode != lpc_pkg::MODE_SLEEP)
		else $error("pins floated outside watch or stop");

	pll_status_a: assert property ( // [RULE_24]
		$changed(pll_st_reg) |-> $past(pcnt_reg) == 19'h0
			&& pll_st_reg == psel_reg)
		else $error("PLL status moved before wait end");

	pll_wait_load_a: assert property ( // [RULE_12]
		to_pll |=> pcnt_reg == lpc_pkg::PLL_WAIT_CYC && pll_st_reg
			&& tbt_clear)
		else $error("PLL wait not started with timebase clear");

	lpm_read_a: assert property ( // [RULE_07]
		rd_lpm |=> reg_rdata[7:6] == 2'h0 && reg_rdata[4:3] == 2'h3)
		else $error("write-only bits read wrong");

	ws_keep_a: assert property ( // [RULE_14]
		disable iff (rst_por)
		rst_src.ext && !rst_por && !wr_cks |=> $stable(ws_reg))
		else $error("wait select lost on pin reset");

	sub_prio_a: assert property ( // [RULE_16]
		!sub_st_reg |-> clk_src == lpc_pkg::SRC_SUB)
		else $error("subclock not chosen");

	pause_map_a: assert property ( // [RULE_08]
		pause_reg == 2'h2 |-> pause_cycles == lpc_pkg::PAUSE_2)
		else $error("pause length wrong");

	pause_keep_a: assert property ( // [RULE_09]
		disable iff (rst_full)
		rst_src.ext && !wr_lpm |=> $stable(pause_reg))
		else $error("pause field lost on pin reset");

	stop_stby_a: assert property ( // [RULE_05]
		mode == lpc_pkg::MODE_STOP |-> stby.periph_stop
			&& stby.sub_osc_stop && stby.pins_hiz == float_reg)
		else $error("stop mode controls wrong");

endmodule // low_power_clock_select

// *** low_power_clock_select_bench.sv ***
// Self-checking bench for the low-power clock select block
`timescale 1ns/100ps
module low_power_clock_select_bench;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] r;
		logic [5:0] o;
	} row_s;
	logic clk;
	logic rst;
	lpc_pkg::rst_src_s rst_src;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic irq_pending;
	logic wake_irq;
	lpc_pkg::mode_e mode;
	lpc_pkg::stby_s stby;
	lpc_pkg::clk_src_e clk_src;
	logic [2:0] pll_factor;
	logic [5:0] pause_cycles;
	logic osc_wait;
	logic tbt_clear;
	logic sw_reset;
	int n_errors;
	int n_tests;
	int n;
	row_s rows [10];

	// Short waits keep the stop-release counts cheap to simulate
	low_power_clock_select #(.WAIT_1(8), .WAIT_2(16), .WAIT_3(32),
		.SUB_WAIT(4)) u_low_power_clock_select (
		.clk(clk), .rst(rst), .rst_src(rst_src), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq_pending(irq_pending),
		.wake_irq(wake_irq), .mode(mode), .stby(stby), .clk_src(clk_src),
		.pll_factor(pll_factor), .pause_cycles(pause_cycles),
		.osc_wait(osc_wait), .tbt_clear(tbt_clear), .sw_reset(sw_reset));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkm(input lpc_pkg::mode_e exp);
		n_tests++;
		if (mode !== exp) begin
			n_errors++;
			$display("Error at %0t: mode %0d expected %0d", $time, mode, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	task automatic wake;
		@(posedge clk);
		wake_irq <= 1'b1;
		@(posedge clk);
		wake_irq <= 1'b0;
		#1;
	endtask

	// Counts the cycles spent in the stabilization state after a wake
	task automatic count_wake;
		n = 0;
		while (mode === lpc_pkg::MODE_WAKE && n < 5000) begin
			@(posedge clk);
			#1 n++;
		end
	endtask

	task automatic pulse(input lpc_pkg::rst_src_s s);
		@(posedge clk);
		rst_src <= s;
		@(posedge clk);
		rst_src <= '0;
	endtask

	initial begin
		#2000000;
		n_errors++;
		tally_and_finish();
	end

	initial begin
		n_errors = 0;
		n_tests = 0;
		rst = 1'b1;
		rst_src = '0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		// Held pending so table rows never enter a low-power mode
		irq_pending = 1'b1;
		wake_irq = 1'b0;
		rows = '{'{8'ha0, 8'h18, 8'h18, 6'h00}, '{8'ha0, 8'h1a, 8'h1a, 6'h09},
			'{8'ha0, 8'h1c, 8'h1c, 6'h11}, '{8'ha0, 8'h1e, 8'h1e, 6'h21},
			'{8'ha1, 8'h3c, 8'hfc, 6'h01}, '{8'ha1, 8'hfd, 8'hfd, 6'h02},
			'{8'ha1, 8'hfe, 8'hfe, 6'h03}, '{8'ha1, 8'hff, 8'hff, 6'h04},
			'{8'ha2, 8'hff, 8'h00, 6'h00}, '{8'ha0, 8'h9e, 8'h1e, 6'h21}};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(8'ha0, 8'h18);
		rd(8'ha1, 8'hfc);
		chkm(lpc_pkg::MODE_RUN);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].r);
			if (rows[i].a == 8'ha0) begin
				chk(pause_cycles, rows[i].o);
			end else if (rows[i].a == 8'ha1) begin
				chk(pll_factor, rows[i].o);
			end
		end
		// Pending interrupt holds the block in run
		@(posedge clk);
		irq_pending <= 1'b1;
		wr(8'ha0, 8'h5f);
		#1 chkm(lpc_pkg::MODE_RUN);
		@(posedge clk);
		irq_pending <= 1'b0;
		wr(8'ha0, 8'h5f);
		#1 chkm(lpc_pkg::MODE_SLEEP);
		chk(stby.cpu_halt, 1'b1);
		chk(stby.self_refresh, 1'b1);
		wake();
		chkm(lpc_pkg::MODE_RUN);
		wr(8'ha0, 8'h17);
		#1 chkm(lpc_pkg::MODE_WATCH);
		wake();
		chkm(lpc_pkg::MODE_RUN);
		wr(8'ha0, 8'hff);
		#1 chkm(lpc_pkg::MODE_STOP);
		chk(stby.pins_hiz, 1'b1);
		chk(stby.self_refresh, 1'b1);
		chk(tbt_clear, 1'b1);
		chk({stby.periph_stop, stby.main_osc_stop,
			stby.sub_osc_stop}, 3'h7);
		wake();
		count_wake();
		chk(n, 16'd33);
		rd(8'ha0, 8'h3f);
		chk(stby.pins_hiz, 1'b0);
		wr(8'ha1, 8'hf7);
		repeat (10) @(posedge clk);
		rd(8'ha1, 8'h77);
		chk(clk_src, lpc_pkg::SRC_SUB);
		wr(8'ha1, 8'hff);
		#1 chk(tbt_clear, 1'b1);
		chk(osc_wait, 1'b1);
		repeat (40) @(posedge clk);
		rd(8'ha1, 8'hff);
		chk(clk_src, lpc_pkg::SRC_MAIN);
		wr(8'ha1, 8'hfb);
		#1 chk(tbt_clear, 1'b1);
		wr(8'ha1, 8'hf8);
		rd(8'ha1, 8'hfb);
		repeat (4100) @(posedge clk);
		rd(8'ha1, 8'hbb);
		chk(clk_src, lpc_pkg::SRC_PLL);
		chk(pll_factor, 3'h4);
		wr(8'ha0, 8'h9f);
		#1 chkm(lpc_pkg::MODE_PSEUDO);
		chk({stby.periph_stop, stby.main_osc_stop,
			stby.sub_osc_stop}, 3'h4);
		wake();
		count_wake();
		chk(n, 16'd4097);
		pulse(4'b0001);
		rd(8'ha0, 8'h1e);
		rd(8'ha1, 8'hbb);
		wr(8'ha0, 8'h0e);
		#1;
		for (int k = 0; k < 4; k++) begin
			chk(sw_reset, k == 2);
			@(posedge clk);
			#1;
		end
		rd(8'ha0, 8'h1e);
		rd(8'ha1, 8'hbb);
		wr(8'ha1, 8'h9b);
		rd(8'ha1, 8'h9b);
		pulse(4'b0010);
		rd(8'ha1, 8'hdc);
		rd(8'ha0, 8'h18);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		rd(8'ha1, 8'hfc);
		tally_and_finish();
	end
endmodule // low_power_clock_select_bench
